/* File: rtl/btr_router.sv */
// Backplane trigger router: exports internal events on TTL/ECL trigger lines,
// imports one selected line as a trigger, and acts as a bus interrupter.
// Assumes single-clock logic on mclk; pins are open-drain style, resolved outside.
//
// Behaviour
// - Exports are one-way broadcasts; no acknowledge is awaited.
// - Each exported line is driven from one selected source.
// - Enable-qualify source pulses when qualifying event enables first trigger.
// - Trigger A and B sources pulse on each valid subsystem trigger.
// - Operation-complete source comes from event status operation-complete bit.
// - Expression source pulses when expression trigger function evaluates true.
// - TTL reset defaults: 0,4 qualify; 1,5 A; 2,6 B; 3,7 complete.
// - ECL reset defaults: line 0 trigger B, line 1 trigger A.
// - At most one TTL or ECL line is selected for import at once.
// - Import edge is rising or falling by a polarity setting.
// - Interrupter on levels 1 to 7, with acknowledge participation.
`timescale 1ns/1ns
`default_nettype none
module btr_router (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Internal event sources
   input  wire logic        enable_qualify,
   input  wire logic        trigger_a_event,
   input  wire logic        trigger_b_event,
   input  wire logic [7:0]  event_status,
   input  wire logic        expression_trigger_function,
   // TTL trigger lines (active low, open drain)
   input  wire logic [7:0]  ttl_trig_n_i,
   output logic      [7:0]  ttl_trig_n_o,
   output logic      [7:0]  ttl_trig_oe,
   // ECL trigger lines (active high levels)
   input  wire logic [1:0]  ecl_trig_i,
   output logic      [1:0]  ecl_trig_o,
   output logic      [1:0]  ecl_trig_oe,
   // Imported trigger
   output logic             import_trigger,
   // Bus interrupter
   output logic      [7:1]  irq_n_o,
   output logic      [7:1]  irq_n_oe,
   input  wire logic        iack_n_i,
   input  wire logic        iackin_n_i,
   input  wire logic [2:0]  iack_level_i,
   output logic             iackout_n_o,
   output logic      [7:0]  irq_vector_o,
   output logic             irq_vector_oe,
   // Interrupt to local processor
   output logic             irq
);
   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   logic [15:0] ttl_sel0_q;
   logic [15:0] ttl_sel1_q;
   logic [7:0]  ecl_sel_q;
   logic [9:0]  exp_en_q;
   logic [5:0]  imp_cfg_q;
   logic [2:0]  irq_level_q;
   logic [7:0]  irq_vec_q;
   logic        irq_req_q;
   logic [btr_pkg::EV_W-1:0] status_q;
   logic [btr_pkg::EV_W-1:0] mask_q;
   logic [btr_pkg::EV_W-1:0] ev_set;

   logic        wr_stb;
   logic        rd_stb;
   assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
   assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

   // Pick a source level by its code
   function automatic logic pick_src(input logic [3:0] code, input logic [5:0] srcs);
      case (code)
         btr_pkg::SRC_ENQUAL: pick_src = srcs[1];
         btr_pkg::SRC_TRIG_A: pick_src = srcs[2];
         btr_pkg::SRC_TRIG_B: pick_src = srcs[3];
         btr_pkg::SRC_OPC:    pick_src = srcs[4];
         btr_pkg::SRC_EXPR:   pick_src = srcs[5];
         default:             pick_src = 1'b0;
      endcase
   endfunction

   // -------------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------------
   logic [9:0] lines_async;
   logic [9:0] lines_sync;
   assign lines_async = {ecl_trig_i, ~ttl_trig_n_i};  // Active-high view

   btr_sync #(.W(10)) u_line_sync (
      .mclk     (mclk),
      .reset    (reset),
      .async_in (lines_async),
      .sync_out (lines_sync)
   );

   // Level rides with the strobes so all three settle together
   logic [4:0] iack_sync;
   btr_sync #(.W(5)) u_iack_sync (
      .mclk     (mclk),
      .reset    (reset),
      .async_in ({iack_level_i, iack_n_i, iackin_n_i}),
      .sync_out (iack_sync)
   );

   // -------------------------------------------------------------------
   // Source conditioning
   // -------------------------------------------------------------------
   logic [5:0] src_q;
   // Sources registered so exported lines come from flip-flops
   always_ff @(posedge mclk) begin
      if (reset) begin
         src_q <= 6'h00;
      end else begin
         src_q[0] <= 1'b0;
         src_q[1] <= enable_qualify;
         src_q[2] <= trigger_a_event;
         src_q[3] <= trigger_b_event;
         src_q[4] <= event_status[btr_pkg::OPC_BIT];
         src_q[5] <= expression_trigger_function;
      end
   end

   // -------------------------------------------------------------------
   // Export drivers
   // -------------------------------------------------------------------
   logic [39:0] all_sel;
   assign all_sel = {ecl_sel_q[7:0], ttl_sel1_q, ttl_sel0_q};

   // Lines are broadcast only: no acceptor handshake exists to stall on
   genvar gi;
   generate
      for (gi = 0; gi < btr_pkg::TTL_LINES; gi++) begin : g_ttl
         logic [3:0] code;
         assign code = all_sel[gi*4 +: 4];
         always_ff @(posedge mclk) begin
            if (reset) begin
               ttl_trig_n_o[gi] <= 1'b1;
               ttl_trig_oe[gi]  <= 1'b0;
            end else begin
               ttl_trig_n_o[gi] <= 1'b0;
               // Drive only while asserted; released otherwise
               ttl_trig_oe[gi]  <= exp_en_q[gi] && (code != btr_pkg::SRC_NONE)
                                   && pick_src(code, src_q);
            end
         end
      end
      for (gi = 0; gi < btr_pkg::ECL_LINES; gi++) begin : g_ecl
         logic [3:0] code;
         assign code = all_sel[32 + gi*4 +: 4];
         always_ff @(posedge mclk) begin
            if (reset) begin
               ecl_trig_o[gi]  <= 1'b0;
               ecl_trig_oe[gi] <= 1'b0;
            end else begin
               ecl_trig_oe[gi] <= exp_en_q[8+gi] && (code != btr_pkg::SRC_NONE);
               ecl_trig_o[gi]  <= pick_src(code, src_q);
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // Trigger import
   // -------------------------------------------------------------------
   logic [3:0] imp_idx;
   logic       imp_lvl_q;
   logic       imp_valid_q;
   logic       imp_edge;
   assign imp_idx = imp_cfg_q[3:0];

   // One line at a time: a single index selects it
   always_ff @(posedge mclk) begin
      if (reset) begin
         imp_lvl_q   <= 1'b0;
         imp_valid_q <= 1'b0;
      end else begin
         imp_lvl_q   <= (imp_idx < 4'd10) ? lines_sync[imp_idx] : 1'b0;
         imp_valid_q <= imp_cfg_q[btr_pkg::IMP_EN_BIT] && (imp_idx < 4'd10);
      end
   end

   logic imp_lvl_d;
   assign imp_lvl_d = (imp_idx < 4'd10) ? lines_sync[imp_idx] : 1'b0;
   // Polarity bit picks rising or falling edge
   assign imp_edge = imp_cfg_q[btr_pkg::IMP_POL_BIT] ? (imp_lvl_q && !imp_lvl_d)
                                                     : (!imp_lvl_q && imp_lvl_d);

   always_ff @(posedge mclk) begin
      if (reset) begin
         import_trigger <= 1'b0;
      end else begin
         import_trigger <= imp_valid_q && imp_edge;
      end
   end

   // -------------------------------------------------------------------
   // Bus interrupter
   // -------------------------------------------------------------------
   logic       iack_prev_q;
   logic       iack_mine;
   logic       iack_start;
   assign iack_start = !iack_sync[0] && iack_prev_q && !iack_sync[1];
   assign iack_mine  = iack_start && irq_req_q && (iack_sync[4:2] == irq_level_q);

   // Request held until acknowledged; level 0 disables the interrupter
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_req_q     <= 1'b0;
         iack_prev_q   <= 1'b1;
         irq_n_o       <= 7'h7F;
         irq_n_oe      <= 7'h00;
         iackout_n_o   <= 1'b1;
         irq_vector_o  <= 8'h00;
         irq_vector_oe <= 1'b0;
      end else begin
         iack_prev_q <= iack_sync[0];
         if (import_trigger && irq_level_q != 3'd0) begin
            irq_req_q <= 1'b1;
         end else if (iack_mine) begin
            irq_req_q <= 1'b0;
         end
         irq_n_o <= 7'h00;
         for (int i = 1; i <= 7; i++) begin
            irq_n_oe[i] <= irq_req_q && (irq_level_q == 3'(i));
         end
         if (iack_mine) begin
            irq_vector_o  <= irq_vec_q;
            irq_vector_oe <= 1'b1;
            iackout_n_o   <= 1'b1;
         end else if (iack_start) begin
            iackout_n_o   <= 1'b0;                                // Pass daisy chain on
         end else if (iack_sync[0]) begin
            iackout_n_o   <= 1'b1;
            irq_vector_oe <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------
   // Event status and local interrupt
   // -------------------------------------------------------------------
   logic opc_prev_q;
   always_ff @(posedge mclk) begin
      if (reset) begin
         opc_prev_q <= 1'b0;
      end else begin
         opc_prev_q <= src_q[4];
      end
   end
   assign ev_set = {src_q[4] && !opc_prev_q, iack_mine, import_trigger};

   // Set wins over read-clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         status_q <= '0;
      end else if (rd_stb && wb_adr_i == btr_pkg::ADDR_STATUS) begin
         status_q <= ev_set;
      end else begin
         status_q <= status_q | ev_set;
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_q & mask_q);
      end
   end

   // -------------------------------------------------------------------
   // Register writes
   // -------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         ttl_sel0_q  <= btr_pkg::TTL_SEL0_RST;
         ttl_sel1_q  <= btr_pkg::TTL_SEL1_RST;
         ecl_sel_q   <= btr_pkg::ECL_SEL_RST;
         exp_en_q    <= btr_pkg::EXP_EN_RST;
         imp_cfg_q   <= 6'h00;
         irq_level_q <= 3'd0;
         irq_vec_q   <= 8'h00;
         mask_q      <= '0;
      end else if (wr_stb) begin
         case (wb_adr_i)
            btr_pkg::ADDR_TTL_SEL0: begin
               if (wb_sel_i[0]) ttl_sel0_q[7:0]  <= wb_dat_i[7:0];
               if (wb_sel_i[1]) ttl_sel0_q[15:8] <= wb_dat_i[15:8];
            end
            btr_pkg::ADDR_TTL_SEL1: begin
               if (wb_sel_i[0]) ttl_sel1_q[7:0]  <= wb_dat_i[7:0];
               if (wb_sel_i[1]) ttl_sel1_q[15:8] <= wb_dat_i[15:8];
            end
            btr_pkg::ADDR_ECL_SEL: begin
               if (wb_sel_i[0]) ecl_sel_q <= wb_dat_i[7:0];
            end
            btr_pkg::ADDR_EXP_EN: begin
               if (wb_sel_i[0]) exp_en_q[7:0] <= wb_dat_i[7:0];
               if (wb_sel_i[1]) exp_en_q[9:8] <= wb_dat_i[9:8];
            end
            btr_pkg::ADDR_IMP_CFG: begin
               if (wb_sel_i[0]) imp_cfg_q <= wb_dat_i[5:0];
            end
            btr_pkg::ADDR_IRQ_CFG: begin
               if (wb_sel_i[0]) irq_level_q <= wb_dat_i[2:0];
               if (wb_sel_i[1]) irq_vec_q   <= wb_dat_i[15:8];
            end
            btr_pkg::ADDR_MASK: begin
               if (wb_sel_i[0]) mask_q <= wb_dat_i[btr_pkg::EV_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Register reads and acknowledge
   // -------------------------------------------------------------------
   // Single-wait answer; unmapped addresses read zero and still acknowledge
   always_ff @(posedge mclk) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         if (rd_stb) begin
            case (wb_adr_i)
               btr_pkg::ADDR_TTL_SEL0: wb_dat_o <= {16'h0000, ttl_sel0_q};
               btr_pkg::ADDR_TTL_SEL1: wb_dat_o <= {16'h0000, ttl_sel1_q};
               btr_pkg::ADDR_ECL_SEL:  wb_dat_o <= {24'h00_0000, ecl_sel_q};
               btr_pkg::ADDR_EXP_EN:   wb_dat_o <= {22'h00_0000, exp_en_q};
               btr_pkg::ADDR_IMP_CFG:  wb_dat_o <= {26'h000_0000, imp_cfg_q};
               btr_pkg::ADDR_IRQ_CFG:  wb_dat_o <= {16'h0000, irq_vec_q, 4'h0,
                                                    irq_req_q, irq_level_q};
               btr_pkg::ADDR_STATUS:   wb_dat_o <= {29'h0000_0000, status_q};
               btr_pkg::ADDR_MASK:     wb_dat_o <= {29'h0000_0000, mask_q};
               btr_pkg::ADDR_LINES:    wb_dat_o <= {22'h00_0000, lines_sync};
               default:                wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/btr_pkg.sv */
// Constants shared by the backplane trigger router and its bench.
// Assumes a single clock (mclk, 10 MHz) and a synchronous active-high reset.
package btr_pkg;
   // -------------------------------------------------------------------
   // Register offsets (byte addresses, one 32-bit word each)
   // -------------------------------------------------------------------
   localparam logic [7:0] ADDR_TTL_SEL0 = 8'h00;  // Lines 0..3 source codes
   localparam logic [7:0] ADDR_TTL_SEL1 = 8'h04;  // Lines 4..7 source codes
   localparam logic [7:0] ADDR_ECL_SEL  = 8'h08;  // ECL lines 0..1 source codes
   localparam logic [7:0] ADDR_EXP_EN   = 8'h0C;  // Export enables
   localparam logic [7:0] ADDR_IMP_CFG  = 8'h10;  // Import select and polarity
   localparam logic [7:0] ADDR_IRQ_CFG  = 8'h14;  // Interrupter level and vector
   localparam logic [7:0] ADDR_STATUS   = 8'h18;  // Sticky events, read clears
   localparam logic [7:0] ADDR_MASK     = 8'h1C;  // Interrupt mask
   localparam logic [7:0] ADDR_LINES    = 8'h20;  // Live line levels

   // -------------------------------------------------------------------
   // Source encodings, one nibble per line
   // -------------------------------------------------------------------
   localparam logic [3:0] SRC_NONE    = 4'h0;
   localparam logic [3:0] SRC_ENQUAL  = 4'h1;
   localparam logic [3:0] SRC_TRIG_A  = 4'h2;
   localparam logic [3:0] SRC_TRIG_B  = 4'h3;
   localparam logic [3:0] SRC_OPC     = 4'h4;
   localparam logic [3:0] SRC_EXPR    = 4'h5;
   localparam int         SRC_W       = 4;

   // -------------------------------------------------------------------
   // Sizes and reset values
   // -------------------------------------------------------------------
   localparam int          TTL_LINES    = 8;
   localparam int          ECL_LINES    = 2;
   localparam int          ALL_LINES    = 10;
   localparam logic [15:0] TTL_SEL0_RST = 16'h4321;
   localparam logic [15:0] TTL_SEL1_RST = 16'h4321;
   localparam logic [7:0]  ECL_SEL_RST  = 8'h23;
   localparam logic [9:0]  EXP_EN_RST   = 10'h3FF;
   localparam int          IMP_POL_BIT  = 4;      // 1 = falling edge
   localparam int          IMP_EN_BIT   = 5;
   localparam int          OPC_BIT      = 0;      // Bit of event status word
   localparam int          EV_W         = 3;      // Status: import, irq ack, opc
   localparam int          EV_IMPORT    = 0;
   localparam int          EV_IACK      = 1;
   localparam int          EV_OPC       = 2;
endpackage

/* File: rtl/btr_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous levels.
// Assumes inputs are unrelated to mclk; stage one feeds stage two only.
`timescale 1ns/1ns
`default_nettype none
module btr_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         reset,
   // Levels
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   // Meta stage is read only by the second stage
   always_ff @(posedge mclk) begin
      if (reset) begin
         meta_q   <= '1;
         sync_out <= '1;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* File: bench/btr_router_properties.sv */
// Port-level checker for the backplane trigger router.
// Assumes a bind onto btr_router; sees its ports only, one clock.
`timescale 1ns/1ns
`default_nettype none
module btr_router_properties (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       reset,
   // Register bus
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   // Trigger lines
   input wire logic [7:0] ttl_trig_n_i,
   input wire logic [7:0] ttl_trig_n_o,
   input wire logic [1:0] ecl_trig_i,
   input wire logic       import_trigger,
   // Interrupter
   input wire logic [7:1] irq_n_o,
   input wire logic [7:1] irq_n_oe,
   input wire logic       iack_n_i,
   input wire logic       iackout_n_o,
   input wire logic       irq_vector_oe,
   input wire logic       irq
);
   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic [3:0] quiet_q;
   logic [9:0] lines_q;
   // Cycles since any line moved; saturates so it never wraps into a false pass
   always_ff @(posedge mclk) begin
      lines_q <= {ecl_trig_i, ttl_trig_n_i};
      if (reset) quiet_q <= 4'hF;
      else if ({ecl_trig_i, ttl_trig_n_i} != lines_q) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   import_single_a: assert property (import_trigger |=> !import_trigger)
      else $error("import pulse longer than one cycle");
   import_cause_a: assert property (import_trigger |-> quiet_q <= 4'h8)
      else $error("import pulse without a recent line edge");
   ttl_low_drive_a: assert property (!$past(reset) |-> ttl_trig_n_o == 8'h00)
      else $error("trigger line drive level not low");
   irq_one_level_a: assert property ($onehot0(irq_n_oe))
      else $error("more than one request level driven");
   irq_pin_low_a: assert property (!$past(reset) |-> irq_n_o == 7'h00)
      else $error("request drive level not low");
   vector_or_pass_a: assert property (!(irq_vector_oe && !iackout_n_o))
      else $error("vector driven while passing acknowledge on");
   iack_release_a: assert property (iack_n_i [*5] |-> !irq_vector_oe && iackout_n_o)
      else $error("acknowledge outputs held after release");
   // Main scenarios
   import_seen_c: cover property (import_trigger);
   vector_seen_c: cover property (irq_vector_oe);
   passed_on_c: cover property (!iackout_n_o);
   irq_seen_c: cover property (irq);
endmodule
`default_nettype wire

/* File: bench/btr_far_end.sv */
// Other chassis modules sharing the trigger lines, and the interrupt handler.
// Assumes the bench steers it at rising edges; lines resolve here.
`timescale 1ns/1ns
`default_nettype none
module btr_far_end (
   // Router side
   input wire logic [7:0] ttl_oe,
   input wire logic [7:0] ttl_n_o,
   input wire logic [1:0] ecl_o,
   input wire logic [1:0] ecl_oe,
   // Commands from the bench
   input wire logic [7:0] ttl_pull,
   input wire logic [1:0] ecl_drive,
   input wire logic       ack_go,
   // Resolved lines
   output logic     [7:0] ttl_n,
   output logic     [1:0] ecl,
   output logic           iack_n,
   output logic           iackin_n
);
   // Pulled-up open drain; nobody here ever answers an export
   assign ttl_n = ~((ttl_oe & ~ttl_n_o) | ttl_pull);
   // Released ECL lines sit at the terminated low level
   assign ecl = (ecl_oe & ecl_o) | ecl_drive;
   // Handler acknowledge strobes, daisy chain entry held with them
   assign iack_n = ~ack_go;
   assign iackin_n = ~ack_go;
endmodule
`default_nettype wire

/* File: bench/btr_router_bench.sv */
// Self-checking bench for the trigger router.
// Assumes btr_far_end models the backplane and the checker is bound below.
`timescale 1ns/1ns
`default_nettype none
module btr_router_bench;
   typedef struct packed {logic [3:0] code; logic [4:0] src; logic on;} btr_row_type;
   logic        mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, import_trigger;
   logic        enable_qualify, trigger_a_event, trigger_b_event, irq, ack_go;
   logic        expression_trigger_function, iackout_n_o, irq_vector_oe;
   logic [7:0]  wb_adr_i, event_status, ttl_trig_n_o, ttl_trig_oe, irq_vector_o, ttl_pull;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [1:0]  ecl_trig_o, ecl_trig_oe, ecl_drive;
   logic [7:1]  irq_n_o, irq_n_oe;
   logic [2:0]  iack_level_i;
   wire  [7:0]  ttl_trig_n_i;
   wire  [1:0]  ecl_trig_i;
   wire         iack_n_i, iackin_n_i;
   int          bad_count, checks;
   btr_row_type rows [8] = '{'{4'h1, 5'h01, 1'b1}, '{4'h1, 5'h1E, 1'b0},
      '{4'h2, 5'h02, 1'b1}, '{4'h2, 5'h1D, 1'b0}, '{4'h3, 5'h04, 1'b1},
      '{4'h4, 5'h08, 1'b1}, '{4'h5, 5'h10, 1'b1}, '{4'h0, 5'h1F, 1'b0}};
   // ----------------------------------------------------------------
   // Design and far side
   // ----------------------------------------------------------------
   btr_router uut (.mclk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .enable_qualify, .trigger_a_event, .trigger_b_event,
      .event_status, .expression_trigger_function, .ttl_trig_n_i, .ttl_trig_n_o,
      .ttl_trig_oe, .ecl_trig_i, .ecl_trig_o, .ecl_trig_oe, .import_trigger, .irq_n_o,
      .irq_n_oe, .iack_n_i, .iackin_n_i, .iack_level_i, .iackout_n_o, .irq_vector_o,
      .irq_vector_oe, .irq);
   btr_far_end far (.ttl_oe(ttl_trig_oe), .ttl_n_o(ttl_trig_n_o), .ecl_o(ecl_trig_o),
      .ecl_oe(ecl_trig_oe), .ttl_pull, .ecl_drive, .ack_go, .ttl_n(ttl_trig_n_i),
      .ecl(ecl_trig_i), .iack_n(iack_n_i), .iackin_n(iackin_n_i));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk_pin(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // Classic cycle: hold until ack, take data there, one idle cycle after
   // No wait limit of its own; the watchdog ends a hang
   task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge mclk);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
      wb_xfer(1'b0, a, 32'h0000_0000);
      chk_pin($sformatf("register %h", a), e, rd);
   endtask
   // Sets import config and line levels, counts import pulses
   task automatic imp_run(input logic [31:0] c, input logic [9:0] lv, input logic [31:0] e);
      logic [31:0] n;
      wb_xfer(1'b1, btr_pkg::ADDR_IMP_CFG, c);
      {ecl_drive, ttl_pull} <= lv;
      n = 32'h0000_0000;
      repeat (10) begin
         @(posedge mclk);
         if (import_trigger === 1'b1) n++;
      end
      chk_pin("import pulses", e, n);
   endtask
   // Handler acknowledge cycle at level l
   task automatic hs(input logic [2:0] l, input logic v, input logic p, input logic [6:0] r);
      iack_level_i <= l;
      ack_go <= 1'b1;
      repeat (6) @(posedge mclk);
      chk_pin("vector enable", 32'(v), 32'(irq_vector_oe));
      chk_pin("acknowledge out", 32'(p), 32'(iackout_n_o));
      chk_pin("request levels", 32'(r), 32'(irq_n_oe));
      if (v) chk_pin("vector", 32'h0000_00A5, 32'(irq_vector_o));
      ack_go <= 1'b0;
      repeat (6) @(posedge mclk);
      chk_pin("vector released", 32'h0, 32'(irq_vector_oe));
   endtask
   task tally_and_finish;
      $display("Checks %0d, mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Clock, watchdog and sequence
   // ----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // Whole run is under 300 cycles; a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      {reset, bad_count, checks} = {1'b1, 64'h0};
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {enable_qualify, trigger_a_event, trigger_b_event, expression_trigger_function} = '0;
      {event_status, ttl_pull, ecl_drive, ack_go, iack_level_i} = '0;
      wb_sel_i = 4'hF;
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      foreach (rows[i]) begin
         wb_xfer(1'b1, btr_pkg::ADDR_TTL_SEL0, {16'h0000, {4{rows[i].code}}});
         wb_xfer(1'b1, btr_pkg::ADDR_ECL_SEL, {24'h00_0000, {2{rows[i].code}}});
         {expression_trigger_function, event_status[0], trigger_b_event, trigger_a_event,
            enable_qualify} <= rows[i].src;
         repeat (3) @(posedge mclk);
         chk_pin("ttl enables", 32'({4{rows[i].on}}), 32'(ttl_trig_oe[3:0]));
         chk_pin("ecl levels", 32'({2{rows[i].on}}), 32'(ecl_trig_o));
         chk_pin("ecl enables", 32'({2{rows[i].code != 4'h0}}), 32'(ecl_trig_oe));
      end
      reset <= 1'b1;
      {event_status[0], trigger_b_event, trigger_a_event, enable_qualify} <= 4'h3;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      chk_reg(btr_pkg::ADDR_TTL_SEL0, 32'h0000_4321);
      chk_reg(btr_pkg::ADDR_TTL_SEL1, 32'h0000_4321);
      chk_reg(btr_pkg::ADDR_ECL_SEL, 32'h0000_0023);
      chk_reg(btr_pkg::ADDR_EXP_EN, 32'h0000_03FF);
      chk_reg(8'h3C, 32'h0000_0000);
      chk_pin("default ttl", 32'h0000_0033, 32'(ttl_trig_oe));
      chk_pin("default ecl", 32'h0000_0002, 32'(ecl_trig_o));
      wb_xfer(1'b1, btr_pkg::ADDR_EXP_EN, 32'h0000_0000);
      repeat (3) @(posedge mclk);
      chk_pin("disabled lines", 32'h0, 32'({ecl_trig_oe, ttl_trig_oe}));
      imp_run(32'h0000_0022, 10'h004, 32'h1);
      imp_run(32'h0000_0022, 10'h000, 32'h0);
      imp_run(32'h0000_0032, 10'h004, 32'h0);
      imp_run(32'h0000_0032, 10'h000, 32'h1);
      imp_run(32'h0000_0023, 10'h004, 32'h0);
      imp_run(32'h0000_0028, 10'h100, 32'h1);
      imp_run(32'h0000_0028, 10'h000, 32'h0);
      wb_xfer(1'b1, btr_pkg::ADDR_MASK, 32'h0000_0001);
      repeat (2) @(posedge mclk);
      chk_pin("irq masked in", 32'h1, 32'(irq));
      chk_reg(btr_pkg::ADDR_STATUS, 32'h0000_0001);
      chk_reg(btr_pkg::ADDR_STATUS, 32'h0000_0000);
      chk_pin("irq cleared", 32'h0, 32'(irq));
      wb_xfer(1'b1, btr_pkg::ADDR_IRQ_CFG, 32'h0000_A503);
      imp_run(32'h0000_0028, 10'h100, 32'h1);
      chk_pin("request level", 32'h0000_0004, 32'(irq_n_oe));
      hs(3'd3, 1'b1, 1'b1, 7'h00);
      imp_run(32'h0000_0028, 10'h000, 32'h0);
      imp_run(32'h0000_0028, 10'h100, 32'h1);
      hs(3'd5, 1'b0, 1'b0, 7'h04);
      tally_and_finish();
   end
endmodule
bind btr_router btr_router_properties u_props (.mclk, .reset, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .ttl_trig_n_i, .ttl_trig_n_o, .ecl_trig_i, .import_trigger, .irq_n_o,
   .irq_n_oe, .iack_n_i, .iackout_n_o, .irq_vector_oe, .irq);
`default_nettype wire
